// file: src/hrb_bit_collector.sv
// Serial collector that fills the random byte one noise bit at a time.
// Assumes a synchronised noise bit and a restart pulse from a data read.
`timescale 1ns/1ps
module hrb_bit_collector
  import hrb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic restart,
  input wire logic noise_bit,
  output logic [7:0] random_byte,
  output logic byte_done,
  output logic idle
);

  hrb_col_state_t state_reg;
  logic [3:0] div_reg;
  logic [2:0] cnt_reg;
  logic step;

  // Bit-rate enable; gated by run so nothing shifts once the enable bit is low
  assign step = (state_reg == COL_RUN) && run && (div_reg == BIT_DIV_LAST);
  assign idle = (state_reg != COL_RUN);

  always_ff @(posedge sys_clk) begin
    if (reset || state_reg != COL_RUN || step) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // State; a partial byte is kept while stopped
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= COL_IDLE;
    end else begin
      unique case (state_reg)
        COL_IDLE: if (run) state_reg <= COL_RUN;
        COL_RUN: begin
          if (!run) begin
            state_reg <= COL_IDLE;
          end else if (step && cnt_reg == BYTE_LAST) begin
            state_reg <= COL_FULL;
          end
        end
        COL_FULL: if (restart) state_reg <= run ? COL_RUN : COL_IDLE;
        default: state_reg <= COL_IDLE;
      endcase
    end
  end

  // Last bit lands in this cycle; the ready flag and the full state rise together
  assign byte_done = step && (cnt_reg == BYTE_LAST);

  // Shift register and bit count
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      random_byte <= DATA_RST;
      cnt_reg <= 3'h0;
    end else begin
      if (step) begin
        random_byte <= {random_byte[6:0], noise_bit};
        cnt_reg <= cnt_reg + 3'h1;
      end
    end
  end

endmodule

// file: src/hrb_noise_sync.sv
// Two-stage synchroniser for the external noise bit.
// Assumes the noise input may change at any time.
`timescale 1ns/1ps
module hrb_noise_sync
  import hrb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic noise_in,
  output logic noise_sync
);

  logic meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_reg <= 1'b0;
      noise_sync <= 1'b0;
    end else begin
      meta_reg <= noise_in;
      noise_sync <= meta_reg;
    end
  end

endmodule

// file: src/hrb_pkg.sv
// Shared constants and types of the random byte source.
// Assumes one 50 MHz clock and a 32-bit classic Wishbone slave port.
package hrb_pkg;

  // Register indices as printed; the byte address is four times the index
  localparam logic [31:0] IDX_HW_STATUS = 32'hFFBC015F;
  localparam logic [31:0] IDX_DATA_STATUS = 32'hFFBC0160;
  localparam logic [31:0] IDX_DATA = 32'hFFBC0161;
  localparam logic [31:0] IDX_IRQ_STATUS = 32'hFFBC0162;
  localparam logic [31:0] IDX_IRQ_CLEAR = 32'hFFBC0163;
  localparam logic [31:0] IDX_IRQ_ENABLE = 32'hFFBC0164;
  // Low index bits compared by the decoder (byte address bits 11:2)
  localparam int DEC_W = 10;

  // Field positions
  localparam int HW_ENABLE_BIT = 0;
  localparam int HW_PRESENT_BIT = 6;
  localparam int DS_VALID_BIT = 0;
  localparam int IRQ_READY_BIT = 0;
  localparam int IRQ_STALE_BIT = 1;
  localparam int IRQ_W = 2;

  // Reset values
  localparam logic [7:0] HW_STATUS_RST = 8'h40;
  localparam logic [7:0] DATA_STATUS_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h40;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // Timing: one noise bit is taken per bit period
  localparam int CLK_PERIOD_NS = 20;
  localparam int BIT_PERIOD_NS = 160;
  localparam int BIT_DIV = (BIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] BIT_DIV_LAST = 4'(BIT_DIV - 1);
  localparam logic [2:0] BYTE_LAST = 3'h7;

  // Collector states, Gray coded along idle -> collect -> full
  typedef enum logic [1:0] {
    COL_IDLE = 2'b00,
    COL_RUN = 2'b01,
    COL_FULL = 2'b11
  } hrb_col_state_t;

  // Wishbone request and answer bundles
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
  } hrb_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } hrb_wb_rsp_t;

endpackage

// file: src/hrb_top.sv
// Random byte source: register file, valid flag and interrupt logic.
// Assumes a classic Wishbone master and one noise bit from outside.
//
// How it works
// - while enabled, noise bits shift one per step into the 8-bit byte.
// - a completely filled byte sets the ready flag to 1.
// - reading the random byte clears the ready flag at once.
// - status bit 6 is read-only, 1 when a usable generator exists.
// - status bit 0 is read/write; 1 runs the generator, 0 stops it.
// - data status bit 0 shows the ready flag; bits 7:1 read zero.
// - the generator sits in a low-power idle state when not collecting.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
module hrb_top
  import hrb_pkg::*;
#(
  parameter bit GEN_PRESENT = 1'b1
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire hrb_wb_req_t wb_req,
  output hrb_wb_rsp_t wb_rsp,
  input wire logic noise_in,
  output logic irq,
  output logic gen_idle
);

  // Word index of a bus address, as seen by the decoder
  function automatic logic [DEC_W-1:0] word_idx(input logic [31:0] adr);
    word_idx = adr[DEC_W+1:2];
  endfunction

  // True when the address selects the given register index
  function automatic logic hit(input logic [31:0] adr, input logic [31:0] idx);
    hit = (word_idx(adr) == idx[DEC_W-1:0]);
  endfunction

  logic generator_on_reg;
  logic output_byte_ready_reg;
  logic output_byte_ready_next;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [IRQ_W-1:0] irq_en_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  logic noise_bit;
  logic [7:0] random_byte;
  logic byte_done;
  logic col_idle;
  logic req;
  logic wr;
  logic rd;
  logic lane0;
  logic rd_data;
  logic wr_hw;
  logic wr_clr;
  logic wr_en;
  logic [IRQ_W-1:0] irq_event;

  // Bus request, taken in the first cycle of a strobe
  assign req = wb_req.cyc && wb_req.stb && !ack_reg;
  assign wr = req && wb_req.we;
  assign rd = req && !wb_req.we;
  assign lane0 = wb_req.sel[0];
  assign rd_data = rd && hit(wb_req.adr, IDX_DATA);
  assign wr_hw = wr && lane0 && hit(wb_req.adr, IDX_HW_STATUS);
  assign wr_clr = wr && lane0 && hit(wb_req.adr, IDX_IRQ_CLEAR);
  assign wr_en = wr && lane0 && hit(wb_req.adr, IDX_IRQ_ENABLE);

  // Noise input brought into the clock domain
  hrb_noise_sync i_hrb_noise_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .noise_in(noise_in),
    .noise_sync(noise_bit)
  );

  // Serial collector, run only while enabled
  hrb_bit_collector i_hrb_bit_collector (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(generator_on_reg),
    .restart(rd_data),
    .noise_bit(noise_bit),
    .random_byte(random_byte),
    .byte_done(byte_done),
    .idle(col_idle)
  );

  // Low-power idle whenever no bits are being collected
  assign gen_idle = col_idle;

  // Enable bit; held low when no generator exists
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      generator_on_reg <= HW_STATUS_RST[HW_ENABLE_BIT];
    end else if (wr_hw) begin
      generator_on_reg <= wb_req.dat[HW_ENABLE_BIT] && GEN_PRESENT;
    end
  end

  // Ready flag: set on a full byte, cleared by a data read, set wins
  always_comb begin
    output_byte_ready_next = output_byte_ready_reg;
    if (rd_data) begin
      output_byte_ready_next = 1'b0;
    end
    if (byte_done) begin
      output_byte_ready_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      output_byte_ready_reg <= DATA_STATUS_RST[DS_VALID_BIT];
    end else begin
      output_byte_ready_reg <= output_byte_ready_next;
    end
  end

  // Interrupt events: byte ready, and a read of a byte not yet ready
  always_comb begin
    irq_event = '0;
    irq_event[IRQ_READY_BIT] = byte_done;
    irq_event[IRQ_STALE_BIT] = rd_data && !output_byte_ready_reg;
  end

  // Sticky status; a clear write loses to a new event
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_clr) begin
      irq_stat_next = irq_stat_reg & ~wb_req.dat[IRQ_W-1:0];
    end
    irq_stat_next = irq_stat_next | irq_event;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_stat_reg <= IRQ_RST;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  // Interrupt enable register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_en_reg <= IRQ_RST;
    end else if (wr_en) begin
      irq_en_reg <= wb_req.dat[IRQ_W-1:0];
    end
  end

  // Level interrupt from enabled sticky bits
  assign irq = |(irq_stat_reg & irq_en_reg);

  // Read data mux; unmapped or write-only words read zero
  always_comb begin
    rdat_next = 32'h00000000;
    if (hit(wb_req.adr, IDX_HW_STATUS)) begin
      rdat_next[HW_PRESENT_BIT] = GEN_PRESENT;
      rdat_next[HW_ENABLE_BIT] = generator_on_reg;
    end else if (hit(wb_req.adr, IDX_DATA_STATUS)) begin
      rdat_next[DS_VALID_BIT] = output_byte_ready_reg;
    end else if (hit(wb_req.adr, IDX_DATA)) begin
      rdat_next[7:0] = random_byte;
    end else if (hit(wb_req.adr, IDX_IRQ_STATUS)) begin
      rdat_next[IRQ_W-1:0] = irq_stat_reg;
    end else if (hit(wb_req.adr, IDX_IRQ_ENABLE)) begin
      rdat_next[IRQ_W-1:0] = irq_en_reg;
    end
  end

  // Answer one cycle after the strobe; ack stands for one cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else begin
      ack_reg <= req;
      if (rd) begin
        rdat_reg <= rdat_next;
      end
    end
  end

  assign wb_rsp.ack = ack_reg;
  assign wb_rsp.dat = rdat_reg;

  // Checks on the block's own behaviour
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // Ready flag rises only after a full byte
  a_ready_rise: assert property (
    $rose(output_byte_ready_reg) |-> $past(byte_done))
    else $error("ready flag rose without a full byte");

  // A full byte always raises the flag next cycle
  a_done_sets: assert property (
    byte_done |=> output_byte_ready_reg)
    else $error("full byte did not set ready flag");

  // Data read clears the flag unless a byte lands at once
  a_read_clears: assert property (
    rd_data && !byte_done |=> !output_byte_ready_reg)
    else $error("data read did not clear ready flag");

  // No shifting while the generator is off
  a_off_no_shift: assert property (
    !generator_on_reg && !$past(generator_on_reg) |=> $stable(random_byte))
    else $error("byte changed while generator off");

  // No new ready flag while off
  a_off_no_flag: assert property (
    !generator_on_reg[*2] ##0 !output_byte_ready_reg |=> !output_byte_ready_reg)
    else $error("ready flag set while generator off");

  // Hardware status reads present and enable bits
  a_hw_read: assert property (
    rd && hit(wb_req.adr, IDX_HW_STATUS) |=>
      wb_rsp.ack && wb_rsp.dat[HW_PRESENT_BIT] == GEN_PRESENT
      && wb_rsp.dat[HW_ENABLE_BIT] == $past(generator_on_reg)
      && wb_rsp.dat[7] == 1'b0)
    else $error("hardware status read wrong");

  // Enable write takes effect on the next cycle
  a_enable_write: assert property (
    wr_hw |=> generator_on_reg == ($past(wb_req.dat[HW_ENABLE_BIT]) && GEN_PRESENT))
    else $error("enable bit not written");

  // Data status mirrors the flag with zero upper bits
  a_status_map: assert property (
    rd && hit(wb_req.adr, IDX_DATA_STATUS) |=>
      wb_rsp.dat[7:0] == {7'h00, $past(output_byte_ready_reg)})
    else $error("data status read wrong");

  // Collector drops to idle one cycle after the enable bit goes low
  a_idle_off: assert property (
    !generator_on_reg |=> gen_idle)
    else $error("collector awake while disabled");

  // Enabling wakes the collector unless a byte is still waiting
  a_wake_on: assert property (
    $rose(generator_on_reg) |=> !gen_idle || output_byte_ready_reg)
    else $error("collector did not wake on enable");

  // A waiting byte is never overwritten before it is read
  a_full_hold: assert property (
    output_byte_ready_reg && !rd_data |=> $stable(random_byte))
    else $error("waiting byte changed before read");

  // Every change of the byte is one left shift
  a_shift_order: assert property (
    !$stable(random_byte) |->
      random_byte[7:1] == $past(random_byte[6:0]))
    else $error("byte changed other than by a shift");

  // The new bit is the synchronised noise bit
  a_noise_in: assert property (
    !$stable(random_byte) |-> random_byte[0] == $past(noise_bit))
    else $error("shifted bit is not the noise bit");

  // Ready flag stands until the byte is read
  a_ready_stays: assert property (
    output_byte_ready_reg && !rd_data |=> output_byte_ready_reg)
    else $error("ready flag dropped without a read");

  // Hardware status reads the present bit and zero reserved bits
  a_present_bit: assert property (
    rd && hit(wb_req.adr, IDX_HW_STATUS) |=>
      wb_rsp.dat[6:1] == {GEN_PRESENT, 5'h00})
    else $error("present or reserved bits wrong");

  // Writes to the data status word leave the flag alone
  a_ds_readonly: assert property (
    wr && hit(wb_req.adr, IDX_DATA_STATUS) && !byte_done |=>
      $stable(output_byte_ready_reg))
    else $error("data status changed by a write");

  // A read of a byte not yet ready is recorded
  a_stale_event: assert property (
    rd_data && !output_byte_ready_reg |=> irq_stat_reg[IRQ_STALE_BIT])
    else $error("stale read not recorded");

  // Sticky ready event holds until cleared by a write of one
  a_sticky_hold: assert property (
    irq_stat_reg[IRQ_READY_BIT] && !(wr_clr && wb_req.dat[IRQ_READY_BIT]) |=>
      irq_stat_reg[IRQ_READY_BIT])
    else $error("sticky status bit lost");

  // A clear write with no new event empties the written bits
  a_clear_bits: assert property (
    wr_clr && irq_event == '0 |=>
      (irq_stat_reg & $past(wb_req.dat[IRQ_W-1:0])) == '0)
    else $error("clear write left a status bit set");

  // An enabled ready event raises the interrupt
  a_irq_raise: assert property (
    irq_event[IRQ_READY_BIT] && irq_en_reg[IRQ_READY_BIT] && !wr_en |=> irq)
    else $error("enabled event did not raise irq");

  // Words above the map read zero
  a_unmapped_zero: assert property (
    rd && (word_idx(wb_req.adr) > IDX_IRQ_ENABLE[DEC_W-1:0]) |=>
      wb_rsp.dat == 32'h00000000)
    else $error("unmapped word read nonzero");

  // Upper read data lanes stay zero
  a_upper_zero: assert property (
    wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h000000)
    else $error("upper read lanes nonzero");

  // No answer without a request
  a_no_ack_idle: assert property (
    !(wb_req.cyc && wb_req.stb) |=> !wb_rsp.ack)
    else $error("ack without a request");

  // Every taken request is answered next cycle
  a_req_acked: assert property (
    req |=> wb_rsp.ack)
    else $error("request not answered");

  // No second byte completes in the eight cycles after a full byte
  a_byte_spacing: assert property (
    byte_done |=> !byte_done [*8])
    else $error("bytes completed too close together");

  // Ack is a single-cycle pulse
  a_ack_pulse: assert property (
    ack_reg |=> !ack_reg)
    else $error("ack held more than one cycle");

  c_byte_ready: cover property (byte_done ##[1:40] rd_data);
  c_enable_on: cover property (wr_hw ##1 generator_on_reg);
  c_stale_read: cover property (rd_data && !output_byte_ready_reg);
  c_irq_raised: cover property ($rose(irq));
  c_pause_resume: cover property ($fell(generator_on_reg) ##[1:300] $rose(generator_on_reg));

endmodule

// file: verif/hrb_top_bench.sv
// Self-checking bench of the random byte source, driven over classic Wishbone.
// Assumes hrb_pkg and hrb_top from src; the bench drives every port itself.
`timescale 1ns/1ps
module hrb_top_bench;
  import hrb_pkg::*;

  localparam logic [31:0] A_HW = {IDX_HW_STATUS[29:0], 2'b00};
  localparam logic [31:0] A_DS = {IDX_DATA_STATUS[29:0], 2'b00};
  localparam logic [31:0] A_DAT = {IDX_DATA[29:0], 2'b00};
  localparam logic [31:0] A_IS = {IDX_IRQ_STATUS[29:0], 2'b00};
  localparam logic [31:0] A_IC = {IDX_IRQ_CLEAR[29:0], 2'b00};
  localparam logic [31:0] A_IE = {IDX_IRQ_ENABLE[29:0], 2'b00};
  localparam logic [31:0] A_BAD = 32'h000005A0;
  localparam int TIME_LIMIT = 20000;

  logic sys_clk;
  logic reset;
  logic noise_in;
  hrb_wb_req_t wb_req;
  hrb_wb_rsp_t wb_rsp;
  logic irq;
  logic gen_idle;
  logic [7:0] rd;
  int failures;
  int n_tests;
  int cycles;

  hrb_top #(.GEN_PRESENT(1'b1)) i_hrb_top (
    .sys_clk(sys_clk),
    .reset(reset),
    .wb_req(wb_req),
    .wb_rsp(wb_rsp),
    .noise_in(noise_in),
    .irq(irq),
    .gen_idle(gen_idle)
  );

  // Free-running 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Cuts a hung run short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == TIME_LIMIT) begin
      failures++;
      $display("mismatch at %0t: run exceeded cycle limit", $time);
      stop_test();
    end
  end

  // Prints the counts and the verdict, then ends the run
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compares one byte and reports a difference
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One classic Wishbone cycle; holds the request until ack is sampled high
  task automatic wb(input logic we, input logic [31:0] adr, input logic [7:0] dat,
                    output logic [7:0] q);
    @(posedge sys_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, dat: {24'h0, dat}, sel: 4'h1};
    // Only the cycle limit ends a wait for the answer
    do begin
      @(posedge sys_clk);
    end while (wb_rsp.ack !== 1'b1);
    q = wb_rsp.dat[7:0];
    wb_req <= '0;
  endtask

  // Polls the data status until the ready flag shows, with a bounded count
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      wb(1'b0, A_DS, 8'h00, rd);
      k++;
    end while (rd[DS_VALID_BIT] !== 1'b1 && k < 60);
    check8(rd, 8'h01, "ready flag after collection");
  endtask

  // Reset values and outputs after reset
  task automatic t_reset();
    wb(1'b0, A_HW, 8'h00, rd);
    check8(rd, HW_STATUS_RST, "hw status reset");
    wb(1'b0, A_DS, 8'h00, rd);
    check8(rd, DATA_STATUS_RST, "data status reset");
    wb(1'b0, A_DAT, 8'h00, rd);
    check8(rd, DATA_RST, "data reset");
    check8({7'h0, gen_idle}, 8'h01, "idle after reset");
    check8({7'h0, irq}, 8'h00, "irq after reset");
  endtask

  // Read-only places and an unmapped address
  task automatic t_access();
    wb(1'b1, A_HW, 8'h00, rd);
    wb(1'b0, A_HW, 8'h00, rd);
    check8(rd, 8'h40, "present bit not writable");
    wb(1'b1, A_DS, 8'hFF, rd);
    wb(1'b0, A_DS, 8'h00, rd);
    check8(rd, 8'h00, "data status read-only");
    wb(1'b0, A_BAD, 8'h00, rd);
    check8(rd, 8'h00, "unmapped read");
  endtask

  // Full byte of ones, ready flag, interrupt mask and clear, read clears flag
  task automatic t_collect();
    noise_in <= 1'b1;
    wb(1'b1, A_HW, 8'h01, rd);
    wb(1'b0, A_HW, 8'h00, rd);
    check8(rd, 8'h41, "enable bit set");
    wb(1'b0, A_DAT, 8'h00, rd);
    repeat (2) @(posedge sys_clk);
    check8({7'h0, gen_idle}, 8'h00, "busy while collecting");
    wait_ready();
    check8({7'h0, irq}, 8'h00, "irq masked");
    wb(1'b1, A_IE, 8'h01, rd);
    repeat (2) @(posedge sys_clk);
    check8({7'h0, irq}, 8'h01, "irq enabled");
    wb(1'b0, A_IS, 8'h00, rd);
    check8(rd, 8'h03, "irq status ready and stale read");
    wb(1'b1, A_IC, 8'h03, rd);
    repeat (2) @(posedge sys_clk);
    check8({7'h0, irq}, 8'h00, "irq cleared");
    wb(1'b0, A_DAT, 8'h00, rd);
    check8(rd, 8'hFF, "byte of ones");
    wb(1'b0, A_DS, 8'h00, rd);
    check8(rd, 8'h00, "flag cleared by read");
  endtask

  // Disable mid-byte, stay idle, then resume and complete the byte
  task automatic t_pause();
    noise_in <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wb(1'b0, A_DAT, 8'h00, rd);
    repeat (20) @(posedge sys_clk);
    wb(1'b1, A_HW, 8'h00, rd);
    repeat (200) @(posedge sys_clk);
    check8({7'h0, gen_idle}, 8'h01, "idle while disabled");
    wb(1'b0, A_DS, 8'h00, rd);
    check8(rd, 8'h00, "no flag while disabled");
    wb(1'b1, A_HW, 8'h01, rd);
    wait_ready();
    wb(1'b0, A_DAT, 8'h00, rd);
    check8(rd, 8'h00, "byte of zeros after resume");
    check8(rd ^ 8'hFF, 8'hFF, "byte not stuck at ones");
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    noise_in = 1'b0;
    wb_req = '0;
    failures = 0;
    n_tests = 0;
    cycles = 0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_access();
    t_collect();
    t_pause();
    stop_test();
  end
endmodule
